// ---- hw/ffss_flag_gen.sv ----
`timescale 1ns/10ps
module ffss_flag_gen
    import ffss_pkg::*;
#(
    parameter int CNT_W = 6
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [CNT_W-1:0] fifo_count,
    input wire logic [CNT_W-1:0] fifo_threshold,
    input wire logic [CNT_W-1:0] fifo_depth,
    input wire logic fifo_overflow,
    input wire ffss_dmode_e data_mode,
    output ffss_flags_s flags
);

    logic mode_ok;

    // Flags only live in buffered modes
    assign mode_ok = (data_mode == FFSS_DM_FIFO) || (data_mode == FFSS_DM_PACKET);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags <= '0;
        end
        else
        begin
            flags.full <= mode_ok && (fifo_count >= fifo_depth);
            flags.has_data <= mode_ok && (fifo_count != '0);
            flags.level <= mode_ok && (fifo_count >= fifo_threshold);
            flags.overrun <= mode_ok && fifo_overflow;
        end
    end

    a_flag_mode_gate: assert property (@(posedge clk) disable iff (rst)
        !$past(mode_ok) |-> (flags == '0)) else $error("flag set outside buffered mode");
    a_empty_drops: assert property (@(posedge clk) disable iff (rst)
        (fifo_count == '0) |=> !flags.has_data) else $error("has-data stayed set");
    a_level_follows: assert property (@(posedge clk) disable iff (rst)
        mode_ok && (fifo_count >= fifo_threshold) |=> flags.level)
        else $error("level flag missed");
    a_overrun_follows: assert property (@(posedge clk) disable iff (rst)
        mode_ok |=> (flags.overrun == $past(fifo_overflow)))
        else $error("overrun flag wrong");

endmodule

// ---- hw/ffss_pkg.sv ----
package ffss_pkg;

    localparam logic [7:0] FFSS_ADDR_FLAGS = 8'h44;
    localparam logic [7:0] FFSS_ADDR_SIGNAL_STRENGTH = 8'h45;
    localparam logic [7:0] FFSS_ADDR_FUNC = 8'h46;

    localparam int FFSS_BIT_FULL = 6;
    localparam int FFSS_BIT_HAS_DATA = 5;
    localparam int FFSS_BIT_LEVEL = 4;
    localparam int FFSS_BIT_OVERRUN = 3;
    localparam int FFSS_BIT_FLUSH = 2;
    localparam int FFSS_BIT_TIMER_HALT = 6;
    localparam int FFSS_BIT_TEST_EN = 5;
    localparam int FFSS_BIT_HS_SERIAL = 2;

    localparam logic [7:0] FFSS_FUNC_RESET = 8'h00;
    localparam logic [7:0] FFSS_FUNC_WMASK = 8'h64;
    localparam logic [7:0] FFSS_SIGNAL_STRENGTH_RESET = 8'h00;
    localparam int FFSS_FILTER_SHIFT = 3;

    typedef enum logic [2:0]
    {
        FFSS_OP_PUP = 3'h0,
        FFSS_OP_SLEEP = 3'h1,
        FFSS_OP_STBY = 3'h2,
        FFSS_OP_TUNE = 3'h3,
        FFSS_OP_RX = 3'h4,
        FFSS_OP_EEPROM = 3'h5
    } ffss_op_e;

    typedef enum logic [1:0]
    {
        FFSS_DM_DIRECT = 2'h0,
        FFSS_DM_FIFO = 2'h1,
        FFSS_DM_PACKET = 2'h2
    } ffss_dmode_e;

    typedef struct packed
    {
        logic full;
        logic has_data;
        logic level;
        logic overrun;
    } ffss_flags_s;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffss_req_s;

endpackage

// ---- hw/ffss_regs.sv ----
`timescale 1ns/10ps
// Summary of operation
// - The four queue flags are set only in FIFO or packet data mode.
// - Flag register bit 6 reads 1 while the queue is full and clears itself otherwise.
// - Flag register bit 5 reads 1 whenever the queue holds unread bytes.
// - The has-data flag drops by itself as soon as the queue is empty.
// - Bit 4 reads 1 while the unread count is at or above the threshold.
// - Bit 3 reads 1 while the queue is in overrun and clears when that ends.
// - Writing 1 to bit 2 discards the queue contents; 0 does nothing and is the default.
// - The flush bit acts only in standby, tune, receive or EEPROM state.
// - Entering sleep empties the queue and resets the packet handler by itself.
// - Register 0x45 shows the current signal strength, updated during receive.
// - The strength value is low-pass filtered before it is shown.
// - A signal weaker than the squelch threshold reads as strength 0.
// - Function enable bit 6 set to 1 halts the sleep timer; 0 leaves it alone.
// - The function enable register sits at address 0x46.
module ffss_regs
    import ffss_pkg::*;
#(
    parameter int CNT_W = 6,
    parameter logic [CNT_W-1:0] FIFO_DEPTH = 6'd32
)
(
    input wire logic clk,
    input wire logic rst,
    input wire ffss_req_s req,
    output logic [7:0] rdata,
    input wire ffss_op_e op_state,
    input wire ffss_dmode_e data_mode,
    input wire logic [CNT_W-1:0] fifo_count,
    input wire logic [CNT_W-1:0] fifo_threshold,
    input wire logic fifo_overflow,
    input wire logic [7:0] signal_strength_raw,
    input wire logic [7:0] squelch_threshold,
    output logic fifo_flush,
    output logic packet_reset,
    output logic sleep_timer_halt,
    output logic test_mode_en,
    output logic hs_serial_en
);

    ffss_flags_s flags;
    logic [7:0] signal_strength_value;
    logic [7:0] function_enable_reg;
    logic [7:0] rdata_next;
    logic flush_allowed;
    logic in_sleep;
    logic in_sleep_reg;
    logic flag_wr;

    function automatic logic hit(input ffss_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    ffss_flag_gen #(
        .CNT_W(CNT_W)
    ) u_flags (
        .clk(clk),
        .rst(rst),
        .fifo_count(fifo_count),
        .fifo_threshold(fifo_threshold),
        .fifo_depth(FIFO_DEPTH),
        .fifo_overflow(fifo_overflow),
        .data_mode(data_mode),
        .flags(flags)
    );

    ffss_signal_strength_filter u_signal_strength (
        .clk(clk),
        .rst(rst),
        .in_rx(op_state == FFSS_OP_RX),
        .signal_strength_raw(signal_strength_raw),
        .squelch_threshold(squelch_threshold),
        .signal_strength_out(signal_strength_value)
    );

    assign flush_allowed = (op_state == FFSS_OP_STBY) || (op_state == FFSS_OP_TUNE)
        || (op_state == FFSS_OP_RX) || (op_state == FFSS_OP_EEPROM);
    assign in_sleep = (op_state == FFSS_OP_SLEEP);
    assign flag_wr = hit(req, FFSS_ADDR_FLAGS);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            in_sleep_reg <= 1'b0;
        end
        else
        begin
            in_sleep_reg <= in_sleep;
        end
    end

    // Flush pulse from host write or sleep entry
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fifo_flush <= 1'b0;
            packet_reset <= 1'b0;
        end
        else
        begin
            fifo_flush <= (flag_wr && req.wdata[FFSS_BIT_FLUSH] && flush_allowed)
                || (in_sleep && !in_sleep_reg);
            packet_reset <= in_sleep && !in_sleep_reg;
        end
    end

    // Only writable bits of function enable stored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            function_enable_reg <= FFSS_FUNC_RESET;
        end
        else if (hit(req, FFSS_ADDR_FUNC))
        begin
            function_enable_reg <= req.wdata & FFSS_FUNC_WMASK;
        end
    end

    assign sleep_timer_halt = function_enable_reg[FFSS_BIT_TIMER_HALT];
    assign test_mode_en = function_enable_reg[FFSS_BIT_TEST_EN];
    assign hs_serial_en = function_enable_reg[FFSS_BIT_HS_SERIAL];

    // Status reads; writes to status never land here
    always_comb
    begin
        rdata_next = 8'h00;
        case (req.addr)
            FFSS_ADDR_FLAGS:
            begin
                rdata_next[FFSS_BIT_FULL] = flags.full;
                rdata_next[FFSS_BIT_HAS_DATA] = flags.has_data;
                rdata_next[FFSS_BIT_LEVEL] = flags.level;
                rdata_next[FFSS_BIT_OVERRUN] = flags.overrun;
            end
            FFSS_ADDR_SIGNAL_STRENGTH:
            begin
                rdata_next = signal_strength_value;
            end
            FFSS_ADDR_FUNC:
            begin
                rdata_next = function_enable_reg;
            end
            default:
            begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
        end
        else if (req.rd)
        begin
            rdata <= rdata_next;
        end
    end

    a_flush_gated: assert property (@(posedge clk) disable iff (rst)
        flag_wr && req.wdata[FFSS_BIT_FLUSH] && flush_allowed |=> fifo_flush)
        else $error("flush write not acted on");
    a_flush_state_only: assert property (@(posedge clk) disable iff (rst)
        fifo_flush |-> $past(flush_allowed) || $past(in_sleep))
        else $error("flush outside allowed state");
    a_sleep_entry_clear: assert property (@(posedge clk) disable iff (rst)
        in_sleep && !in_sleep_reg |=> fifo_flush && packet_reset)
        else $error("sleep entry did not clear");
    a_halt_follows_write: assert property (@(posedge clk) disable iff (rst)
        hit(req, FFSS_ADDR_FUNC) |=> (sleep_timer_halt == $past(req.wdata[FFSS_BIT_TIMER_HALT])))
        else $error("halt bit not stored");
    a_func_bit7_zero: assert property (@(posedge clk) disable iff (rst)
        !function_enable_reg[7]) else $error("reserved bit stored");
    a_flag_read: assert property (@(posedge clk) disable iff (rst)
        req.rd && (req.addr == FFSS_ADDR_FLAGS) |=> (rdata[7] == 1'b0)
        && (rdata[FFSS_BIT_FULL] == $past(flags.full)))
        else $error("flag read wrong");
    a_strength_read: assert property (@(posedge clk) disable iff (rst)
        req.rd && (req.addr == FFSS_ADDR_SIGNAL_STRENGTH) |=> (rdata == $past(signal_strength_value)))
        else $error("strength read wrong");
    a_flag_low_zero: assert property (@(posedge clk) disable iff (rst)
        req.rd && (req.addr == FFSS_ADDR_FLAGS) |=> (rdata[2:0] == 3'h0))
        else $error("flag low bits not zero");
    a_pkt_sleep_only: assert property (@(posedge clk) disable iff (rst)
        packet_reset |-> $past(in_sleep)) else $error("packet reset outside sleep");
    a_has_data_read: assert property (@(posedge clk) disable iff (rst)
        req.rd && (req.addr == FFSS_ADDR_FLAGS) |=> (rdata[FFSS_BIT_HAS_DATA]
        == $past(flags.has_data))) else $error("has-data read wrong");

endmodule

// ---- hw/ffss_signal_strength_filter.sv ----
`timescale 1ns/10ps
module ffss_signal_strength_filter
    import ffss_pkg::*;
#(
    parameter int SHIFT = FFSS_FILTER_SHIFT
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_rx,
    input wire logic [7:0] signal_strength_raw,
    input wire logic [7:0] squelch_threshold,
    output logic [7:0] signal_strength_out
);

    logic [7+SHIFT:0] acc_reg;
    logic [7+SHIFT:0] acc_next;
    logic [7:0] avg;

    assign avg = acc_reg[7+SHIFT:SHIFT];
    // First-order low-pass: acc += raw - acc/2^SHIFT
    assign acc_next = acc_reg + {{SHIFT{1'b0}}, signal_strength_raw} - {{SHIFT{1'b0}}, avg};

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_reg <= '0;
        end
        else if (in_rx)
        begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            signal_strength_out <= FFSS_SIGNAL_STRENGTH_RESET;
        end
        else if (in_rx)
        begin
            signal_strength_out <= (avg < squelch_threshold) ? 8'h00 : avg;
        end
    end

    a_squelch_zero: assert property (@(posedge clk) disable iff (rst)
        in_rx && (avg < squelch_threshold) |=> (signal_strength_out == 8'h00))
        else $error("weak signal not squelched");
    a_filter_bounded: assert property (@(posedge clk) disable iff (rst)
        in_rx && (avg >= squelch_threshold) |=> (signal_strength_out == $past(avg)))
        else $error("reading not filtered value");
    a_hold_outside_rx: assert property (@(posedge clk) disable iff (rst)
        !in_rx |=> $stable(signal_strength_out)) else $error("reading changed outside rx");

endmodule

// ---- testbench/ffss_host.sv ----
`timescale 1ns/10ps
module ffss_host
    import ffss_pkg::*;
(
    input wire logic clk,
    output ffss_req_s req,
    input wire logic [7:0] rdata
);
    initial req = '0;

    // Reserved bits 7, 1 and 0 always go out as 0
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data & 8'h7c};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        #1 data = rdata;
    endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb
    import ffss_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ffss_req_s req;
    logic [7:0] rdata;
    ffss_op_e op_state = FFSS_OP_STBY;
    ffss_dmode_e data_mode = FFSS_DM_FIFO;
    logic [5:0] fifo_count = 6'h00;
    logic [5:0] fifo_threshold = 6'h04;
    logic fifo_overflow = 1'b0;
    logic [7:0] signal_strength_raw = 8'h00;
    logic [7:0] squelch_threshold = 8'h00;
    logic fifo_flush, packet_reset, sleep_timer_halt, test_mode_en, hs_serial_en;
    int bad_count = 0;
    int compares = 0;
    int nflush = 0;
    int npkt = 0;
    int base, pbase;
    logic [7:0] v;
    ffss_op_e ops [5] = '{FFSS_OP_STBY, FFSS_OP_TUNE, FFSS_OP_RX, FFSS_OP_EEPROM, FFSS_OP_PUP};

    always #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        if (fifo_flush === 1'b1)
            nflush++;
        if (packet_reset === 1'b1)
            npkt++;
    end

    ffss_host h (.clk(clk), .req(req), .rdata(rdata));

    ffss_regs uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .op_state(op_state),
        .data_mode(data_mode), .fifo_count(fifo_count), .fifo_threshold(fifo_threshold),
        .fifo_overflow(fifo_overflow), .signal_strength_raw(signal_strength_raw),
        .squelch_threshold(squelch_threshold), .fifo_flush(fifo_flush),
        .packet_reset(packet_reset), .sleep_timer_halt(sleep_timer_halt),
        .test_mode_en(test_mode_en), .hs_serial_en(hs_serial_en));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic read_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        h.read_reg(addr, d);
        chk(name, exp, d);
    endtask

    task automatic flag_case(input ffss_dmode_e m, input logic [5:0] c, input logic [5:0] t,
        input logic o, input logic [7:0] e);
        @(posedge clk);
        data_mode <= m;
        fifo_count <= c;
        fifo_threshold <= t;
        fifo_overflow <= o;
        read_chk("flags", FFSS_ADDR_FLAGS, e);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        read_chk("func_reset", FFSS_ADDR_FUNC, FFSS_FUNC_RESET);
        read_chk("signal_strength_reset", FFSS_ADDR_SIGNAL_STRENGTH, FFSS_SIGNAL_STRENGTH_RESET);
        read_chk("unmapped", 8'h50, 8'h00);
        $display("test reset done");
        flag_case(FFSS_DM_FIFO, 6'h00, 6'h04, 1'b0, 8'h00);
        flag_case(FFSS_DM_FIFO, 6'h03, 6'h04, 1'b0, 8'h20);
        flag_case(FFSS_DM_FIFO, 6'h04, 6'h04, 1'b0, 8'h30);
        flag_case(FFSS_DM_FIFO, 6'h20, 6'h04, 1'b0, 8'h70);
        flag_case(FFSS_DM_FIFO, 6'h1f, 6'h04, 1'b0, 8'h30);
        flag_case(FFSS_DM_PACKET, 6'h20, 6'h28, 1'b1, 8'h68);
        flag_case(FFSS_DM_PACKET, 6'h05, 6'h04, 1'b0, 8'h30);
        flag_case(FFSS_DM_DIRECT, 6'h20, 6'h04, 1'b1, 8'h00);
        flag_case(FFSS_DM_FIFO, 6'h05, 6'h04, 1'b0, 8'h30);
        h.write_reg(FFSS_ADDR_FLAGS, 8'h78);
        read_chk("flags_write", FFSS_ADDR_FLAGS, 8'h30);
        $display("test flags done");
        foreach (ops[i])
        begin
            @(posedge clk);
            op_state <= ops[i];
            base = nflush;
            h.write_reg(FFSS_ADDR_FLAGS, 8'h04);
            repeat (3) @(posedge clk);
            chk("flush", (ops[i] == FFSS_OP_PUP) ? 8'h00 : 8'h01, 8'(nflush - base));
        end
        @(posedge clk);
        op_state <= FFSS_OP_STBY;
        base = nflush;
        h.write_reg(FFSS_ADDR_FLAGS, 8'h00);
        repeat (3) @(posedge clk);
        chk("flush_zero", 8'h00, 8'(nflush - base));
        base = nflush;
        pbase = npkt;
        op_state <= FFSS_OP_SLEEP;
        repeat (4) @(posedge clk);
        chk("sleep_flush", 8'h01, 8'(nflush - base));
        chk("sleep_pkt", 8'h01, 8'(npkt - pbase));
        base = nflush;
        h.write_reg(FFSS_ADDR_FLAGS, 8'h04);
        repeat (3) @(posedge clk);
        chk("flush_sleep", 8'h00, 8'(nflush - base));
        $display("test flush done");
        h.write_reg(FFSS_ADDR_FUNC, 8'h64);
        read_chk("func", FFSS_ADDR_FUNC, 8'h64);
        chk("func_out", 8'h07, {5'h00, sleep_timer_halt, test_mode_en, hs_serial_en});
        h.write_reg(FFSS_ADDR_FUNC, 8'h00);
        repeat (2) @(posedge clk);
        chk("func_clear", 8'h00, {5'h00, sleep_timer_halt, test_mode_en, hs_serial_en});
        $display("test function done");
        @(posedge clk);
        op_state <= FFSS_OP_RX;
        signal_strength_raw <= 8'h80;
        h.read_reg(FFSS_ADDR_SIGNAL_STRENGTH, v);
        chk("signal_strength_slow", 8'h01, 8'(v < 8'h80));
        repeat (200) @(posedge clk);
        read_chk("signal_strength", FFSS_ADDR_SIGNAL_STRENGTH, 8'h80);
        h.write_reg(FFSS_ADDR_SIGNAL_STRENGTH, 8'h11);
        read_chk("signal_strength_write", FFSS_ADDR_SIGNAL_STRENGTH, 8'h80);
        squelch_threshold <= 8'h90;
        repeat (5) @(posedge clk);
        read_chk("signal_strength_squelch", FFSS_ADDR_SIGNAL_STRENGTH, 8'h00);
        squelch_threshold <= 8'h00;
        repeat (5) @(posedge clk);
        op_state <= FFSS_OP_STBY;
        signal_strength_raw <= 8'h10;
        repeat (20) @(posedge clk);
        read_chk("signal_strength_hold", FFSS_ADDR_SIGNAL_STRENGTH, 8'h80);
        $display("test strength done");
        report_and_stop();
    end
endmodule
